// [logic/abbp_bus_master.v]
// Notes on behaviour
// - Read starts by driving address onto shared lines
// - Sync strobe rises only after address settles
// - Release address, then raise data-in strobe
// - On reply, capture data then drop data-in
// - Sync dropped only after reply is gone
// - No reply in timeout: abandon, trap vector 10
// - Read-modify-write uses one sync assertion
// - Byte variants write only one byte
// - Interrupt request answered by acknowledge, vector returned
// - DMA ownership suspends only bus transactions
// - Low 28K words memory, top 4K I/O
// - Init line while DC bad or commanded
// - DC good: init and wait; AC good: run
// - AC loss takes power-fail trap, vector 24
// - Power-up restarts only after DC drops
// - Run indicator pulses once per instruction fetch
// - Refresh qualifier marks refresh address phase
`timescale 1ns/100ps
`include "abbp_consts.vh"
module abbp_bus_master #(
  parameter TMO_CYCLES = `ABBP_REPLY_TMO_CYC,
  parameter INIT_HOLD = `ABBP_INIT_HOLD_CYC
) (
  input wire ref_clk,
  input wire rst,
  input wire cmd_valid,
  output wire cmd_ready,
  input wire [2:0] cmd_kind,
  input wire [15:0] cmd_addr,
  input wire [15:0] cmd_wdata,
  output wire mod_ready,
  input wire mod_valid,
  input wire [15:0] mod_data,
  output reg rsp_valid,
  output reg [15:0] rsp_data,
  output reg rsp_err,
  output reg rsp_io_space,
  output reg trap_valid,
  output reg [15:0] trap_vector,
  input wire [15:0] dal_in,
  output wire [15:0] dal_out,
  output wire dal_oe,
  output wire bus_sync_strobe,
  output wire data_in_strobe,
  output wire data_out_strobe,
  output wire byte_select,
  input wire slave_reply,
  input wire interrupt_request_line,
  output reg irq_pending,
  output wire interrupt_ack_grant,
  input wire dma_request,
  output reg dma_grant,
  input wire dc_power_good,
  input wire ac_power_good,
  input wire init_cmd,
  output wire system_init_line,
  output wire powerup_start,
  input wire halt_request_line,
  output reg halt_seen,
  input wire fetch_done,
  output reg run_indicator_pulse,
  output wire refresh_qualifier
);
  // Bus cycle states
  localparam S_IDLE = 4'h0; // No cycle; DMA may be granted here
  localparam S_ADDR = 4'h1; // Address driven, letting it settle
  localparam S_SYNC = 4'h2; // Sync up, address still held for latching
  localparam S_DIN = 4'h3; // Data-in strobe up, waiting for reply
  localparam S_DIN_END = 4'h4; // Data-in down, waiting for reply to drop
  localparam S_MODIFY = 4'h5; // Read half of RMW done, sync still up
  localparam S_DOUT = 4'h6; // Write data driven, data-out up
  localparam S_DOUT_END = 4'h7; // Data-out down, waiting for reply to drop
  localparam S_FINISH = 4'h8; // Sync dropped, cycle ends
  localparam S_IACK = 4'h9; // Interrupt acknowledge with data-in
  localparam S_IACK_END = 4'hA; // Acknowledge dropped, waiting for reply to drop

  reg [3:0] st_q;
  reg [3:0] st_d;
  reg [2:0] kind_q; // Kind of the cycle in flight
  reg [15:0] addr_q; // Latched target address
  reg [15:0] wdata_q; // Data for the write half
  reg err_q; // Current cycle was abandoned
  reg bto_pend_q; // Bus timeout trap waiting behind a power-fail trap
  wire tmo_hit; // Reply wait expired this cycle
  wire pf_trap; // Power-fail trap event
  wire waiting; // A strobe is up and no reply yet

  // Byte address falls in the I/O page
  function is_io;
    input [15:0] a;
    begin
      is_io = (a >= `ABBP_IO_BASE);
    end
  endfunction

  // Byte-wide write halves
  function is_byte_kind;
    input [2:0] k;
    begin
      is_byte_kind = (k == `ABBP_CMD_WRITE_BYTE) || (k == `ABBP_CMD_RMW_BYTE);
    end
  endfunction

  // Read-modify-write kinds
  function is_rmw_kind;
    input [2:0] k;
    begin
      is_rmw_kind = (k == `ABBP_CMD_RMW) || (k == `ABBP_CMD_RMW_BYTE);
    end
  endfunction

  abbp_power_seq #(
    .INIT_HOLD(INIT_HOLD)
  ) u_pwr (
    .ref_clk(ref_clk),
    .rst(rst),
    .dc_power_good(dc_power_good),
    .ac_power_good(ac_power_good),
    .init_cmd(init_cmd),
    .system_init_line(system_init_line),
    .powerup_start(powerup_start),
    .power_fail_trap(pf_trap)
  );

  // Timer runs only while a strobe is up and unanswered; a reply clears it
  assign waiting = ((st_q == S_DIN) || (st_q == S_DOUT) || (st_q == S_IACK)) && !slave_reply;

  // A missing slave would otherwise hang the bus for good
  abbp_reply_timer #(
    .CYCLES(TMO_CYCLES)
  ) u_tmo (
    .ref_clk(ref_clk),
    .rst(rst),
    .run(waiting),
    .expired(tmo_hit)
  );

  // Commands only while the bus is ours and the system is not in init
  assign cmd_ready = (st_q == S_IDLE) && !dma_grant && !dma_request &&
                     !system_init_line;
  assign mod_ready = (st_q == S_MODIFY);

  // Next bus state
  always @* begin
    st_d = st_q;
    case (st_q)
      S_IDLE: begin
        if (cmd_valid && cmd_ready) begin
          if (cmd_kind == `ABBP_CMD_IACK) begin
            st_d = S_IACK;
          end else begin
            st_d = S_ADDR;
          end
        end
      end
      S_ADDR: begin
        st_d = S_SYNC;
      end
      S_SYNC: begin
        // The address stays one more cycle so slaves can latch the match
        if (kind_q == `ABBP_CMD_WRITE || kind_q == `ABBP_CMD_WRITE_BYTE) begin
          st_d = S_DOUT;
        end else begin
          st_d = S_DIN;
        end
      end
      S_DIN: begin
        if (tmo_hit) begin
          st_d = S_FINISH;
        end else if (slave_reply) begin
          st_d = S_DIN_END;
        end
      end
      S_DIN_END: begin
        if (!slave_reply) begin
          if (is_rmw_kind(kind_q)) begin
            st_d = S_MODIFY;
          end else begin
            st_d = S_FINISH;
          end
        end
      end
      S_MODIFY: begin
        if (mod_valid) begin
          st_d = S_DOUT;
        end
      end
      S_DOUT: begin
        if (tmo_hit) begin
          st_d = S_FINISH;
        end else if (slave_reply) begin
          st_d = S_DOUT_END;
        end
      end
      S_DOUT_END: begin
        if (!slave_reply) begin
          st_d = S_FINISH;
        end
      end
      S_FINISH: begin
        st_d = S_IDLE;
      end
      S_IACK: begin
        // No address phase: the nearest requester answers the grant
        if (tmo_hit) begin
          st_d = S_FINISH;
        end else if (slave_reply) begin
          st_d = S_IACK_END;
        end
      end
      S_IACK_END: begin
        if (!slave_reply) begin
          st_d = S_FINISH;
        end
      end
      default: begin
        st_d = S_IDLE;
      end
    endcase
    // Init wipes any cycle in progress
    if (system_init_line) begin
      st_d = S_IDLE;
    end
  end

  // State and cycle context
  always @(posedge ref_clk) begin
    if (rst) begin
      st_q <= S_IDLE;
      kind_q <= 3'h0;
      addr_q <= 16'h0000;
      wdata_q <= 16'h0000;
      err_q <= 1'b0;
    end else begin
      st_q <= st_d;
      if (st_q == S_IDLE && cmd_valid && cmd_ready) begin
        kind_q <= cmd_kind;
        addr_q <= cmd_addr;
        wdata_q <= cmd_wdata;
        err_q <= 1'b0;
      end else if (st_q == S_MODIFY && mod_valid) begin
        wdata_q <= mod_data; // Modified value goes back to the same address
      end
      if (tmo_hit) begin
        err_q <= 1'b1;
      end
    end
  end

  // Read data, completion and abandon reports
  always @(posedge ref_clk) begin
    if (rst) begin
      rsp_valid <= 1'b0;
      rsp_data <= 16'h0000;
      rsp_err <= 1'b0;
      rsp_io_space <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      rsp_err <= 1'b0;
      if ((st_q == S_DIN || st_q == S_IACK) && slave_reply && !tmo_hit) begin
        rsp_valid <= 1'b1;
        rsp_data <= dal_in;
        rsp_io_space <= is_io(addr_q);
      end else if (st_q == S_DOUT && slave_reply && !tmo_hit) begin
        rsp_valid <= 1'b1;
        rsp_io_space <= is_io(addr_q);
      end else if (tmo_hit) begin
        rsp_valid <= 1'b1;
        rsp_err <= 1'b1;
        rsp_io_space <= is_io(addr_q);
      end
    end
  end

  // Trap reporting; power-fail wins a tie and the bus trap follows
  always @(posedge ref_clk) begin
    if (rst) begin
      trap_valid <= 1'b0;
      trap_vector <= 16'h0000;
      bto_pend_q <= 1'b0;
    end else begin
      trap_valid <= 1'b0;
      if (pf_trap) begin
        trap_valid <= 1'b1;
        trap_vector <= `ABBP_VEC_PWR_FAIL;
        bto_pend_q <= bto_pend_q || tmo_hit;
      end else if (tmo_hit || bto_pend_q) begin
        trap_valid <= 1'b1;
        trap_vector <= `ABBP_VEC_BUS_TMO;
        bto_pend_q <= 1'b0;
      end
    end
  end

  // DMA hand-over: only granted between cycles, held while requested
  // Never raised mid-cycle, so no slave is left half-addressed
  always @(posedge ref_clk) begin
    if (rst) begin
      dma_grant <= 1'b0;
    end else if (system_init_line) begin
      dma_grant <= 1'b0;
    end else if (dma_grant) begin
      dma_grant <= dma_request;
    end else begin
      dma_grant <= dma_request && (st_q == S_IDLE) && !cmd_valid;
    end
  end

  // Status levels and the run pulse
  // Halt is only reported here; acting on it is left to the core
  always @(posedge ref_clk) begin
    if (rst) begin
      irq_pending <= 1'b0;
      halt_seen <= 1'b0;
      run_indicator_pulse <= 1'b0;
    end else begin
      irq_pending <= interrupt_request_line;
      halt_seen <= halt_request_line; // Follows the line; the far end holds it
      run_indicator_pulse <= fetch_done;
    end
  end

  // Pin drive decoded straight from the state register
  // Address leaves the lines in the cycle data-in rises, so they never overlap
  assign dal_oe = (st_q == S_ADDR) || (st_q == S_SYNC) || (st_q == S_DOUT);
  assign dal_out = (st_q == S_DOUT) ? wdata_q : addr_q;
  assign bus_sync_strobe = (st_q == S_SYNC) || (st_q == S_DIN) || (st_q == S_DIN_END) ||
                           (st_q == S_MODIFY) || (st_q == S_DOUT) ||
                           (st_q == S_DOUT_END);
  assign data_in_strobe = ((st_q == S_DIN) && !err_q) || (st_q == S_IACK);
  assign data_out_strobe = (st_q == S_DOUT);
  assign byte_select = (st_q == S_DOUT) && is_byte_kind(kind_q);
  assign interrupt_ack_grant = (st_q == S_IACK);
  assign refresh_qualifier = ((st_q == S_ADDR) || (st_q == S_SYNC)) &&
                             (kind_q == `ABBP_CMD_REFRESH);
endmodule // abbp_bus_master

// [logic/abbp_consts.vh]
`ifndef ABBP_CONSTS_VH
`define ABBP_CONSTS_VH

// Clock period of ref_clk in nanoseconds (10 MHz)
`define ABBP_CLK_PERIOD_NS 100
// Longest wait for a slave reply after a data strobe, in nanoseconds
`define ABBP_REPLY_TMO_NS 10000
// Reply timeout in clock cycles, rounded down
`define ABBP_REPLY_TMO_CYC (`ABBP_REPLY_TMO_NS / `ABBP_CLK_PERIOD_NS)
// Clock cycles the init line is held after an init command
`define ABBP_INIT_HOLD_CYC 16
// Trap vector for a missing reply
`define ABBP_VEC_BUS_TMO 16'h000A
// Trap vector for loss of AC power
`define ABBP_VEC_PWR_FAIL 16'h0018
// Memory and I/O split, in words
`define ABBP_MEM_WORDS 28672
`define ABBP_IO_WORDS 4096
// First byte address of the I/O page (28672 words of two bytes)
`define ABBP_IO_BASE 16'hE000
// Command kinds on the user port
`define ABBP_CMD_READ 3'h0
`define ABBP_CMD_WRITE 3'h1
`define ABBP_CMD_WRITE_BYTE 3'h2
`define ABBP_CMD_RMW 3'h3
`define ABBP_CMD_RMW_BYTE 3'h4
`define ABBP_CMD_REFRESH 3'h5
`define ABBP_CMD_IACK 3'h6

`endif

// [logic/abbp_power_seq.v]
`timescale 1ns/100ps
`include "abbp_consts.vh"
// Power-up / power-fail sequencing from the two power-good inputs
module abbp_power_seq #(
  parameter INIT_HOLD = `ABBP_INIT_HOLD_CYC
) (
  input wire ref_clk,
  input wire rst,
  input wire dc_power_good,
  input wire ac_power_good,
  input wire init_cmd,
  output wire system_init_line,
  output reg powerup_start,
  output reg power_fail_trap
);
  localparam PS_DOWN = 2'h0; // DC bad: system held in init
  localparam PS_WAIT_AC = 2'h1; // DC good, waiting for AC good
  localparam PS_RUN = 2'h2; // Running normally
  localparam PS_FAILED = 2'h3; // AC lost; only a DC drop restarts

  reg [1:0] st_q;
  reg [1:0] st_d;
  reg [7:0] hold_q; // Remaining cycles of a commanded init
  reg [7:0] hold_d;

  // Sequencer next state
  always @* begin
    st_d = st_q;
    case (st_q)
      PS_DOWN: begin
        if (dc_power_good) begin
          st_d = PS_WAIT_AC;
        end
      end
      PS_WAIT_AC: begin
        if (!dc_power_good) begin
          st_d = PS_DOWN;
        end else if (ac_power_good) begin
          st_d = PS_RUN;
        end
      end
      PS_RUN: begin
        if (!dc_power_good) begin
          st_d = PS_DOWN;
        end else if (!ac_power_good) begin
          st_d = PS_FAILED;
        end
      end
      PS_FAILED: begin
        // AC coming back alone does not restart; DC must drop first
        if (!dc_power_good) begin
          st_d = PS_DOWN;
        end
      end
      default: begin
        st_d = PS_DOWN;
      end
    endcase
  end

  // Init stretch: command, or the DC-good edge that starts power-up
  always @* begin
    hold_d = hold_q;
    if (init_cmd || (st_q == PS_DOWN && dc_power_good)) begin
      hold_d = INIT_HOLD[7:0];
    end else if (hold_q != 8'h00) begin
      hold_d = hold_q - 8'h01;
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      st_q <= PS_DOWN;
      hold_q <= 8'h00;
      powerup_start <= 1'b0;
      power_fail_trap <= 1'b0;
    end else begin
      st_q <= st_d;
      hold_q <= hold_d;
      powerup_start <= (st_q == PS_WAIT_AC) && (st_d == PS_RUN);
      power_fail_trap <= (st_q == PS_RUN) && (st_d == PS_FAILED);
    end
  end

  // Held while DC is bad and while a commanded init runs
  assign system_init_line = (st_q == PS_DOWN) || (hold_q != 8'h00);
endmodule // abbp_power_seq

// [logic/abbp_reply_timer.v]
`timescale 1ns/100ps
// Counts cycles while a strobe waits for reply; pulses once on expiry
module abbp_reply_timer #(
  parameter CYCLES = 100
) (
  input wire ref_clk,
  input wire rst,
  input wire run,
  output wire expired
);
  reg [15:0] cnt_q; // Cycles spent waiting so far
  reg [15:0] cnt_d;

  // Next count: cleared whenever the wait is not in progress
  always @* begin
    cnt_d = 16'h0000;
    if (run && cnt_q != CYCLES[15:0]) begin
      cnt_d = cnt_q + 16'h0001;
    end else if (run) begin
      cnt_d = cnt_q; // Saturate so the expiry fires only once
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      cnt_q <= 16'h0000;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // One-cycle pulse on the cycle the limit is reached
  assign expired = run && (cnt_q == CYCLES[15:0] - 16'h0001);
endmodule // abbp_reply_timer

// [verification/abbp_checker.sv]
`timescale 1ns/100ps
// Pin-level watch on handshake order, timeout trap and power sequencing
module abbp_checker #(
  parameter TMO_CYCLES = 8
) (
  input wire ref_clk,
  input wire rst,
  input wire dal_oe,
  input wire bus_sync_strobe,
  input wire data_in_strobe,
  input wire data_out_strobe,
  input wire slave_reply,
  input wire mod_ready,
  input wire rsp_valid,
  input wire trap_valid,
  input wire [15:0] trap_vector,
  input wire dma_grant,
  input wire dc_power_good,
  input wire ac_power_good,
  input wire system_init_line,
  input wire powerup_start,
  input wire fetch_done,
  input wire run_indicator_pulse,
  input wire refresh_qualifier
);
  reg [7:0] wait_q; // Cycles a strobe has waited, saturating
  // Count strobe cycles without reply
  always @(posedge ref_clk) begin
    if (rst || slave_reply || !(data_in_strobe || data_out_strobe)) begin
      wait_q <= 8'h00;
    end else if (wait_q != 8'hFF) begin
      wait_q <= wait_q + 8'h01;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  addr_first_a: assert property ($rose(bus_sync_strobe) |-> $past(dal_oe))
    else $error("sync rose without address phase");
  din_released_a: assert property (data_in_strobe |-> !dal_oe)
    else $error("data-in strobe while driving lines");
  din_drop_a: assert property (data_in_strobe && bus_sync_strobe && slave_reply
    |=> !data_in_strobe && rsp_valid) else $error("data-in not ended on reply");
  sync_end_a: assert property ($fell(bus_sync_strobe) |-> !slave_reply
    && !$past(slave_reply)) else $error("sync dropped before reply gone");
  reply_tmo_a: assert property (int'(wait_q) == TMO_CYCLES
    |-> ##[0:3] trap_valid && trap_vector == 16'h000A) else $error("no timeout trap");
  rmw_sync_a: assert property (mod_ready |-> bus_sync_strobe && !data_in_strobe)
    else $error("sync lost during modify");
  dma_idle_a: assert property (dma_grant |-> !bus_sync_strobe && !dal_oe
    && !data_in_strobe && !data_out_strobe) else $error("bus driven during dma");
  init_dc_a: assert property (!dc_power_good |=> system_init_line)
    else $error("init line low without dc good");
  powerup_a: assert property (powerup_start |-> dc_power_good && $past(ac_power_good))
    else $error("power-up without both supplies");
  pwr_fail_a: assert property ($fell(ac_power_good) && dc_power_good
    && !system_init_line |-> ##[1:3] trap_valid && trap_vector == 16'h0018)
    else $error("no power-fail trap");
  run_pulse_a: assert property (fetch_done |=> run_indicator_pulse)
    else $error("fetch without run pulse");
  refresh_a: assert property (refresh_qualifier |-> dal_oe && !data_in_strobe)
    else $error("refresh qualifier outside address phase");
  rmw_c: cover property (mod_ready);
  tmo_c: cover property (trap_valid && trap_vector == 16'h000A);
  dma_c: cover property (dma_grant);
endmodule // abbp_checker
bind abbp_bus_master abbp_checker #(.TMO_CYCLES(TMO_CYCLES)) chk_u (.*);

// [verification/abbp_slave_model.sv]
`timescale 1ns/100ps
// Behavioural bus slave: word store, interrupt vector, adjustable or muted reply
module abbp_slave_model #(
  parameter VEC = 16'h00C4 // Arbitrary vector returned on acknowledge
) (
  input wire ref_clk,
  input wire rst,
  input wire bus_sync_strobe,
  input wire data_in_strobe,
  input wire data_out_strobe,
  input wire byte_select,
  input wire interrupt_ack_grant,
  input wire system_init_line,
  input wire [15:0] dal_out,
  input wire [3:0] slv_delay,
  input wire slv_mute,
  output reg [15:0] dal_in,
  output reg slave_reply
);
  reg [15:0] mem_q [0:15]; // Word store, address bits 4:1
  reg [4:0] adr_q; // Latched byte address
  reg sync_q; // Sync strobe one cycle ago
  reg [3:0] cnt_q; // Reply delay count
  wire strb = data_in_strobe || data_out_strobe || interrupt_ack_grant;
  // Undriven lines toggle so a stale value never looks valid
  always @(posedge ref_clk) begin
    sync_q <= bus_sync_strobe;
    if (!slave_reply || !strb) begin
      dal_in <= ~dal_in;
    end
    if (bus_sync_strobe && !sync_q) begin
      adr_q <= dal_out[4:0];
    end
    if (rst) begin
      dal_in <= 16'h0F0F;
      slave_reply <= 1'b0;
      cnt_q <= 4'h0;
    end else if (!strb || system_init_line) begin
      // Init clears the reply side of the slave as well
      slave_reply <= 1'b0;
      cnt_q <= 4'h0;
    end else if (!slave_reply && !slv_mute) begin
      cnt_q <= cnt_q + 4'h1;
      if (cnt_q >= slv_delay) begin
        slave_reply <= 1'b1;
        if (interrupt_ack_grant) begin
          // Nearest requester answers and keeps the grant from passing on
          dal_in <= VEC;
        end else if (data_in_strobe) begin
          dal_in <= mem_q[adr_q[4:1]];
        end else if (!byte_select) begin
          mem_q[adr_q[4:1]] <= dal_out;
        end else if (adr_q[0]) begin
          mem_q[adr_q[4:1]][15:8] <= dal_out[15:8];
        end else begin
          mem_q[adr_q[4:1]][7:0] <= dal_out[7:0];
        end
      end
    end
  end
endmodule // abbp_slave_model

// [verification/abbp_tb.sv]
`timescale 1ns/100ps
// Bench: user port stimulus, behavioural slave on the bus side
module tb;
  logic ref_clk, rst, cmd_valid, cmd_ready, mod_ready, mod_valid, rsp_valid, rsp_err;
  logic rsp_io_space, trap_valid, dal_oe, bus_sync_strobe, data_in_strobe, data_out_strobe;
  logic byte_select, slave_reply, interrupt_request_line, irq_pending, interrupt_ack_grant;
  logic dma_request, dma_grant, dc_power_good, ac_power_good, init_cmd, system_init_line;
  logic powerup_start, halt_request_line, halt_seen, fetch_done, run_indicator_pulse;
  logic refresh_qualifier, slv_mute, ref_seen, rerr;
  logic [2:0] cmd_kind;
  logic [3:0] slv_delay;
  logic [15:0] cmd_addr, cmd_wdata, mod_data, rsp_data, trap_vector, dal_in, dal_out;
  logic [15:0] rdat, trap_seen;
  int failures, tests_run, cyc;
  abbp_bus_master #(.TMO_CYCLES(8), .INIT_HOLD(4)) dut_u (.*);
  abbp_slave_model slv_u (.*);
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // Hang guard, and record pulses the tasks may miss
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (trap_valid) begin
      trap_seen <= trap_vector;
    end
    if (refresh_qualifier) begin
      ref_seen <= 1'b1;
    end
    if (cyc == 20000) begin
      failures++;
      end_sim();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %h, expected %h", $time, got, exp);
    end
  endtask
  // One command; read data and error land in rdat and rerr
  task automatic bus(input logic [2:0] k, input logic [15:0] a, input logic [15:0] w);
    @(negedge ref_clk);
    cmd_valid = 1'b1;
    cmd_kind = k;
    cmd_addr = a;
    cmd_wdata = w;
    while (!cmd_ready) @(negedge ref_clk);
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    do @(negedge ref_clk); while (!rsp_valid);
    rdat = rsp_data;
    rerr = rsp_err;
    if ((k == 3'h3 || k == 3'h4) && !rerr) begin
      while (!mod_ready) @(negedge ref_clk);
      mod_valid = 1'b1;
      mod_data = w;
      @(negedge ref_clk);
      mod_valid = 1'b0;
      do @(negedge ref_clk); while (!rsp_valid);
    end
  endtask
  task automatic t_power_up();
    logic [15:0] n = 16'h0000;
    chk(system_init_line, 1);
    dc_power_good = 1'b1;
    repeat (8) @(negedge ref_clk);
    ac_power_good = 1'b1;
    repeat (3) begin
      @(negedge ref_clk);
      n += powerup_start;
    end
    chk(n, 1);
  endtask
  task automatic t_rw();
    bus(3'h1, 16'h0006, 16'h1234);
    bus(3'h2, 16'h0007, 16'hAB00);
    bus(3'h0, 16'h0006, 16'h0000);
    chk(rdat, 16'hAB34);
    chk(rerr, 0);
    bus(3'h0, 16'hDFFE, 16'h0000);
    chk(rsp_io_space, 0);
    slv_delay = 4'h5;
    bus(3'h0, 16'hE000, 16'h0000);
    chk(rsp_io_space, 1);
    chk(ref_seen, 0);
    slv_delay = 4'h1;
  endtask
  task automatic t_rmw();
    bus(3'h3, 16'h0006, 16'h5678);
    chk(rdat, 16'hAB34);
    bus(3'h4, 16'h0006, 16'h00CD);
    chk(rdat, 16'h5678);
    bus(3'h0, 16'h0006, 16'h0000);
    chk(rdat, 16'h56CD);
  endtask
  task automatic t_timeout();
    slv_mute = 1'b1;
    bus(3'h0, 16'h0010, 16'h0000);
    chk(rerr, 1);
    repeat (3) @(negedge ref_clk);
    chk(trap_seen, 16'h000A);
    slv_mute = 1'b0;
  endtask
  task automatic t_refresh_iack();
    bus(3'h5, 16'h0000, 16'h0000);
    chk(ref_seen, 1);
    interrupt_request_line = 1'b1;
    repeat (2) @(negedge ref_clk);
    chk(irq_pending, 1);
    bus(3'h6, 16'h0000, 16'h0000);
    chk(rdat, 16'h00C4);
    interrupt_request_line = 1'b0;
  endtask
  task automatic t_dma_init();
    dma_request = 1'b1;
    while (!dma_grant) @(negedge ref_clk);
    chk(cmd_ready, 0);
    fetch_done = 1'b1;
    @(negedge ref_clk);
    fetch_done = 1'b0;
    chk(run_indicator_pulse, 1);
    halt_request_line = 1'b1;
    @(negedge ref_clk);
    chk(halt_seen, 1);
    halt_request_line = 1'b0;
    @(negedge ref_clk);
    chk(halt_seen, 0);
    dma_request = 1'b0;
    init_cmd = 1'b1;
    @(negedge ref_clk);
    init_cmd = 1'b0;
    chk(system_init_line, 1);
    while (!cmd_ready) @(negedge ref_clk);
  endtask
  task automatic t_power_fail();
    logic [15:0] n = 16'h0000;
    ac_power_good = 1'b0;
    repeat (4) @(negedge ref_clk);
    chk(trap_seen, 16'h0018);
    ac_power_good = 1'b1;
    repeat (4) begin
      @(negedge ref_clk);
      n += powerup_start;
    end
    chk(n, 0);
    dc_power_good = 1'b0;
    @(negedge ref_clk);
    chk(system_init_line, 1);
    dc_power_good = 1'b1;
    repeat (4) begin
      @(negedge ref_clk);
      n += powerup_start;
    end
    chk(n, 1);
  endtask
  task automatic end_sim();
    if (failures == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    {cmd_valid, mod_valid, interrupt_request_line, dma_request, dc_power_good} = '0;
    {ac_power_good, init_cmd, halt_request_line, fetch_done, slv_mute, ref_seen} = '0;
    {cmd_kind, cmd_addr, cmd_wdata, mod_data, trap_seen} = '0;
    slv_delay = 4'h1;
    rst = 1'b1;
    repeat (6) @(negedge ref_clk);
    rst = 1'b0;
    t_power_up();
    t_rw();
    t_rmw();
    t_timeout();
    t_refresh_iack();
    t_dma_init();
    t_power_fail();
    end_sim();
  end
endmodule // tb
